// ### design/dupsl_defines.svh
`ifndef DUPSL_DEFINES_SVH
`define DUPSL_DEFINES_SVH

// Register offsets
`define DUPSL_CH0_CTL   16'h009B
`define DUPSL_CH0_BUF   16'h0099
`define DUPSL_CH1_CTL   16'h009E
`define DUPSL_CH1_BUF   16'h009F
`define DUPSL_PWR_CTL   16'h0087
`define DUPSL_RATE_CTL  16'h00D8
`define DUPSL_MISC_CTL  16'hFFF1

// Reset values
`define DUPSL_CTL_RST   8'h00
`define DUPSL_MISC_RST  8'h00

// Control register fields, shared by both channels except DUPSL_MODE_LO, which channel 1 masks off
`define DUPSL_MODE_HI   7
`define DUPSL_MODE_LO   6
`define DUPSL_MPROC     5
`define DUPSL_REN       4
`define DUPSL_TB8       3
`define DUPSL_RB8       2
`define DUPSL_TI        1
`define DUPSL_RI        0
`define DUPSL_CH0_MASK  8'hFF
`define DUPSL_CH1_MASK  8'hBF

// Miscellaneous and rate fields
`define DUPSL_PDN_BIT   7
`define DUPSL_LPBK_BIT  1
`define DUPSL_SEL_BIT   0
`define DUPSL_DBL_BIT   7
`define DUPSL_RSRC_BIT  7

// Ticks per bit minus one: 12, 64 and 32 ticks
`define DUPSL_LIM_MODE0 6'h0B
`define DUPSL_LIM_FIXED 6'h3F
`define DUPSL_LIM_VAR   6'h1F

// Bits per frame; receive counts leave out the start bit
`define DUPSL_TXB_SYNC  4'h8
`define DUPSL_TXB_NINE  4'hB
`define DUPSL_TXB_EIGHT 4'hA
`define DUPSL_RXB_SYNC  4'h8
`define DUPSL_RXB_NINE  4'hA
`define DUPSL_RXB_EIGHT 4'h9

`endif

// ### design/dupsl_pkg.sv
package dupsl_pkg;
  typedef enum logic [1:0] {rx_idle, rx_start, rx_bits} dupsl_rx_st_t;
endpackage : dupsl_pkg

// ### design/dupsl_uart.sv
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "dupsl_defines.svh"
// Notes on behaviour
// [RQ1] Select bit picks channel driving shared pins
// [RQ2] Loopback feeds selected transmitter to other receiver
// [RQ3] Top misc bit powers whole block down
// [RQ4] Mode 0: clock on tx, data on rx
// [RQ5] Mode 0 receive needs flag clear, enable set
// [RQ6] Async receive starts on start bit, enabled
// [RQ7] Eight-bit frame: start, eight data, stop
// [RQ8] Mode 1 receive: buffer data, stop to ninth
// [RQ9] Mode 1 rate from generator or timer
// [RQ10] Mode 2: eleven bits, fixed 1/32 or 1/64
// [RQ11] Nine-bit modes send and store ninth bit
// [RQ12] Mode 3 like mode 2, variable rate
// [RQ13] Channel 0 mode bits decode 00-11
// [RQ14] Transmit flag set by hardware, software clears
// [RQ15] Channel 1 mode A: eleven bits, ninth bit
// [RQ16] Channel 1 mode A: generator rate only
// [RQ17] Channel 1 mode B: ten bits, stop stored
// [RQ18] Buffer write sends, read gives received byte
// [RQ19] Rate source bit: timer or generator
// [RQ20] Rate double bit doubles bit rate
// [RQ21] Multiprocessor: only ninth-bit-one frames flag (code does this in nine-bit modes; eight-bit modes flag every frame)
// [RQ22] Receive flag set on frame, held till cleared
// [RQ23] Buffer write starts frame when channel connected
module dupsl_uart
  import dupsl_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rdata,
  // Rate ticks
  input  wire logic        timer1_tick,
  input  wire logic        brg_tick,
  // Serial pins
  input  wire logic        rx_line,
  output logic             rx_line_drv,
  output logic             rx_line_oe_b,
  output logic             tx_pin,
  // Power
  output logic             power_down
);

  logic       rx_meta;
  logic       rxd_s;
  logic [7:0] misc;
  logic       dbl;
  logic       rsrc;
  logic [7:0] next_rdata;
  logic       next_tx_pin;
  logic       next_rx_drv;
  logic       next_rx_oe_b;

  wire        sel  = misc[`DUPSL_SEL_BIT];
  wire        lpbk = misc[`DUPSL_LPBK_BIT];
  wire        pd   = misc[`DUPSL_PDN_BIT];
  wire        run  = ~pd; // RQ3

  wire [1:0]  tx_line;
  wire [1:0]  tx_act;
  wire [1:0]  any_act;
  wire [1:0]  sync_w;
  wire [1:0]  sclk_w;
  wire [7:0]  ctl_rd [0:1];
  wire [7:0]  buf_rd [0:1];

  wire wr_misc = wr_stb & (addr == `DUPSL_MISC_CTL);
  wire wr_pwr  = wr_stb & (addr == `DUPSL_PWR_CTL);
  wire wr_rate = wr_stb & (addr == `DUPSL_RATE_CTL);

  // Pin input crosses from outside; only the second stage is used
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_meta <= 1'b1;
      rxd_s   <= 1'b1;
    end else if (clk_en) begin
      rx_meta <= rx_line;
      rxd_s   <= rx_meta;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      misc <= `DUPSL_MISC_RST;
      dbl  <= 1'b0;
      rsrc <= 1'b0;
    end else if (clk_en) begin
      if (wr_misc) begin
        misc <= wdata & 8'h83;
      end
      if (wr_pwr) begin
        dbl <= wdata[`DUPSL_DBL_BIT];
      end
      if (wr_rate) begin
        rsrc <= wdata[`DUPSL_RSRC_BIT];
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      localparam logic        ID    = (ch == 1);
      localparam logic [15:0] CTL_A = (ch == 0) ? `DUPSL_CH0_CTL : `DUPSL_CH1_CTL;
      localparam logic [15:0] BUF_A = (ch == 0) ? `DUPSL_CH0_BUF : `DUPSL_CH1_BUF;
      localparam logic [7:0]  MASK  = (ch == 0) ? `DUPSL_CH0_MASK : `DUPSL_CH1_MASK;

      logic [7:0]   ctl;
      logic [7:0]   rbuf;
      logic [7:0]   next_ctl;
      logic [7:0]   next_rbuf;
      logic         sync;
      logic         nine;
      logic         fixed;
      logic         timer;
      logic         tx_busy;
      logic [10:0]  tx_sh;
      logic [5:0]   tx_cnt;
      logic [3:0]   tx_left;
      logic         next_tx_busy;
      logic [10:0]  next_tx_sh;
      logic [5:0]   next_tx_cnt;
      logic [3:0]   next_tx_left;
      logic         tx_done;
      dupsl_rx_st_t rx_st;
      dupsl_rx_st_t next_rx_st;
      logic [9:0]   rx_sh;
      logic [5:0]   rx_cnt;
      logic [3:0]   rx_left;
      logic         rx_prev;
      logic [9:0]   next_rx_sh;
      logic [5:0]   next_rx_cnt;
      logic [3:0]   next_rx_left;
      logic         rx_take;

      wire wr_ctl = wr_stb & (addr == CTL_A);
      wire wr_buf = wr_stb & (addr == BUF_A);
      wire conn   = (sel == ID); // RQ1
      wire ren    = ctl[`DUPSL_REN];
      wire mp     = ctl[`DUPSL_MPROC];
      wire tb8    = ctl[`DUPSL_TB8];

      if (ch == 0) begin : g_mode0
        assign sync  = ~ctl[`DUPSL_MODE_HI] & ~ctl[`DUPSL_MODE_LO]; // RQ13
        assign nine  = ctl[`DUPSL_MODE_HI]; // RQ13
        assign fixed = ctl[`DUPSL_MODE_HI] & ~ctl[`DUPSL_MODE_LO]; // RQ10
        assign timer = ~rsrc & ~fixed & ~sync; // RQ9 RQ12 RQ19
      end else begin : g_mode1
        assign sync  = 1'b0;
        assign nine  = ~ctl[`DUPSL_MODE_HI]; // RQ15 RQ17
        assign fixed = 1'b0;
        assign timer = 1'b0; // RQ16 RQ17
      end

      // Fixed and shift modes count system clocks directly
      wire       tick = (sync | fixed) ? 1'b1 : (timer ? timer1_tick : brg_tick);
      wire [5:0] base = sync ? `DUPSL_LIM_MODE0 : (fixed ? `DUPSL_LIM_FIXED : `DUPSL_LIM_VAR);
      wire [5:0] lim  = (dbl & ~sync) ? {1'b0, base[5:1]} : base; // RQ20
      wire [5:0] half = {1'b0, lim[5:1]};

      // Receiver input: own pin, or looped transmitter of the other channel
      wire other_tx = (sel != ID) ? tx_line[1-ch] : 1'b1;
      wire rx_in    = lpbk ? other_tx : (conn ? rxd_s : 1'b1); // RQ2

      // A write while busy is dropped rather than corrupting the frame
      wire tx_load = wr_buf & conn & ~tx_busy & run; // RQ23
      wire [10:0] frame = sync ? {3'b111, wdata}
                               : {1'b1, nine ? tb8 : 1'b1, wdata, 1'b0}; // RQ7 RQ11

      always_comb begin
        next_tx_busy = tx_busy;
        next_tx_sh   = tx_sh;
        next_tx_cnt  = tx_cnt;
        next_tx_left = tx_left;
        tx_done      = 1'b0;
        if (!run) begin
          next_tx_busy = 1'b0;
        end else if (tx_load) begin
          next_tx_busy = 1'b1;
          next_tx_cnt  = 6'h00;
          next_tx_sh   = frame;
          next_tx_left = sync ? `DUPSL_TXB_SYNC
                              : (nine ? `DUPSL_TXB_NINE : `DUPSL_TXB_EIGHT); // RQ10 RQ15
        end else if (tx_busy && tick) begin
          if (tx_cnt == lim) begin
            next_tx_cnt  = 6'h00;
            next_tx_sh   = {1'b1, tx_sh[10:1]}; // RQ4
            next_tx_left = tx_left - 4'h1;
            if (tx_left == 4'h1) begin
              next_tx_busy = 1'b0;
              tx_done      = 1'b1;
            end
          end else begin
            next_tx_cnt = tx_cnt + 6'h01;
          end
        end
      end

      wire       arm_sync  = sync & ren & ~ctl[`DUPSL_RI]; // RQ5
      wire       arm_async = ~sync & ren & rx_prev & ~rx_in; // RQ6
      wire [9:0] shin      = {rx_in, rx_sh[9:1]};
      wire [7:0] rx_data   = sync ? shin[9:2] : (nine ? shin[7:0] : shin[8:1]);
      wire       rx_n9     = nine ? shin[8] : shin[9]; // RQ8 RQ11 RQ17
      wire       keep      = ~(mp & nine & ~rx_n9); // RQ21

      always_comb begin
        next_rx_st   = rx_st;
        next_rx_sh   = rx_sh;
        next_rx_cnt  = rx_cnt;
        next_rx_left = rx_left;
        rx_take      = 1'b0;
        if (!run) begin
          next_rx_st = rx_idle;
        end else begin
          unique case (rx_st)
            rx_idle: begin
              next_rx_cnt = 6'h00;
              if (arm_sync) begin
                next_rx_st   = rx_bits;
                next_rx_left = `DUPSL_RXB_SYNC;
              end else if (arm_async) begin
                next_rx_st   = rx_start;
                next_rx_left = nine ? `DUPSL_RXB_NINE : `DUPSL_RXB_EIGHT;
              end
            end
            rx_start: begin
              if (tick) begin
                if (rx_cnt == half) begin
                  next_rx_cnt = 6'h00;
                  // Glitch shorter than half a bit is not a start
                  next_rx_st  = rx_in ? rx_idle : rx_bits; // RQ8
                end else begin
                  next_rx_cnt = rx_cnt + 6'h01;
                end
              end
            end
            rx_bits: begin
              if (tick) begin
                if (rx_cnt == lim) begin
                  next_rx_cnt  = 6'h00;
                  next_rx_sh   = shin;
                  next_rx_left = rx_left - 4'h1;
                  if (rx_left == 4'h1) begin
                    next_rx_st = rx_idle;
                    rx_take    = keep; // RQ21 RQ22
                  end
                end else begin
                  next_rx_cnt = rx_cnt + 6'h01;
                end
              end
            end
          endcase
        end
      end

      // Hardware set wins over a software clear in the same cycle
      always_comb begin
        next_ctl  = wr_ctl ? (wdata & MASK) : ctl;
        next_rbuf = rbuf;
        if (tx_done) begin
          next_ctl[`DUPSL_TI] = 1'b1; // RQ14
        end
        if (rx_take) begin
          next_ctl[`DUPSL_RI] = 1'b1; // RQ22
          next_rbuf           = rx_data; // RQ18
          if (!sync) begin
            next_ctl[`DUPSL_RB8] = rx_n9; // RQ8 RQ11
          end
        end
      end

      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          ctl     <= `DUPSL_CTL_RST;
          rbuf    <= 8'h00;
          tx_busy <= 1'b0;
          tx_sh   <= 11'h7FF;
          tx_cnt  <= 6'h00;
          tx_left <= 4'h0;
        end else if (clk_en) begin
          ctl     <= next_ctl;
          rbuf    <= next_rbuf;
          tx_busy <= next_tx_busy;
          tx_sh   <= next_tx_sh;
          tx_cnt  <= next_tx_cnt;
          tx_left <= next_tx_left;
        end
      end

      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          rx_st   <= rx_idle;
          rx_sh   <= 10'h000;
          rx_cnt  <= 6'h00;
          rx_left <= 4'h0;
          rx_prev <= 1'b1;
        end else if (clk_en) begin
          rx_st   <= next_rx_st;
          rx_sh   <= next_rx_sh;
          rx_cnt  <= next_rx_cnt;
          rx_left <= next_rx_left;
          rx_prev <= rx_in;
        end
      end

      wire       rx_run = sync & (rx_st == rx_bits);
      wire [5:0] ph     = tx_busy ? tx_cnt : rx_cnt;

      // Shift clock low first half of a bit, rising where data is taken
      assign sclk_w[ch]  = (tx_busy | rx_run) ? (ph > half) : 1'b1; // RQ4
      assign tx_line[ch] = tx_busy ? tx_sh[0] : 1'b1;
      assign tx_act[ch]  = tx_busy & sync;
      assign any_act[ch] = tx_busy | rx_run;
      assign sync_w[ch]  = sync;
      assign ctl_rd[ch]  = ctl;
      assign buf_rd[ch]  = rbuf;
    end
  endgenerate

  wire shift0 = sync_w[0] & ~sel;

  assign next_tx_pin  = (shift0 & any_act[0]) ? sclk_w[0] : tx_line[sel]; // RQ1 RQ4
  assign next_rx_oe_b = ~(shift0 & tx_act[0]); // RQ4
  assign next_rx_drv  = (shift0 & tx_act[0]) ? tx_line[0] : 1'b1;

  wire [7:0] misc_rd = misc & 8'h83;
  wire [7:0] pwr_rd  = {dbl, 7'h00};
  wire [7:0] rate_rd = {rsrc, 7'h00};

  always_comb begin
    next_rdata = 8'h00;
    if (rd_stb) begin
      unique case (addr)
        `DUPSL_CH0_CTL:  next_rdata = ctl_rd[0];
        `DUPSL_CH0_BUF:  next_rdata = buf_rd[0]; // RQ18
        `DUPSL_CH1_CTL:  next_rdata = ctl_rd[1];
        `DUPSL_CH1_BUF:  next_rdata = buf_rd[1]; // RQ18
        `DUPSL_PWR_CTL:  next_rdata = pwr_rd;
        `DUPSL_RATE_CTL: next_rdata = rate_rd;
        `DUPSL_MISC_CTL: next_rdata = misc_rd;
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata        <= 8'h00;
      tx_pin       <= 1'b1;
      rx_line_drv  <= 1'b1;
      rx_line_oe_b <= 1'b1;
      power_down   <= 1'b0;
    end else if (clk_en) begin
      rdata        <= next_rdata;
      tx_pin       <= next_tx_pin;
      rx_line_drv  <= next_rx_drv;
      rx_line_oe_b <= next_rx_oe_b;
      power_down   <= pd; // RQ3
    end
  end

endmodule : dupsl_uart

// ### verification/dupsl_host.sv
`timescale 1ns/10ps
module dupsl_host (
  // Clock and serial line
  input  wire logic        sys_clk,
  input  wire logic        tx_pin,
  output logic             rx_line,
  // Frame shape and capture
  input  wire logic [15:0] per,
  input  wire logic [15:0] nb,
  output logic      [9:0]  rx_word,
  output logic      [15:0] rx_cnt
);
  logic [9:0] w;
  initial begin
    rx_line = 1'b1;
    rx_cnt  = 16'h0000;
    rx_word = 10'h000;
  end
  // Samples mid bit; the stop bit is kept so framing shows in the word
  always begin
    @(negedge tx_pin);
    w = 10'h000;
    repeat (per / 2) @(posedge sys_clk);
    if (!tx_pin) begin
      for (int i = 0; i <= nb; i++) begin
        repeat (per) @(posedge sys_clk);
        w[i] = tx_pin;
      end
      // Report only after the stop bit has run out
      repeat (per / 2 + 2) @(posedge sys_clk);
      rx_word = w;
      rx_cnt++;
    end
  end
  task automatic send(input logic [9:0] bits, input int n);
    @(posedge sys_clk);
    rx_line <= 1'b0;
    repeat (per) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      rx_line <= bits[i];
      repeat (per) @(posedge sys_clk);
    end
    rx_line <= 1'b1;
  endtask : send
endmodule : dupsl_host

// ### verification/dupsl_uart_checker.sv
`timescale 1ns/10ps
module dupsl_uart_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Bus and pins
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [7:0]  rdata,
  input wire logic        rx_line_oe_b,
  input wire logic        tx_pin,
  input wire logic        power_down
);
  logic [7:0] misc_s;
  logic [1:0] mode_s;
  logic [9:0] low_n;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Shadows from bus writes, as the register file is out of sight here
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      misc_s <= 8'h00;
      mode_s <= 2'b00;
      low_n  <= 10'h000;
    end else begin
      if (wr_stb && addr == 16'hFFF1) misc_s <= wdata;
      if (wr_stb && addr == 16'h009B) mode_s <= wdata[7:6];
      low_n <= tx_pin ? 10'h000 : low_n + 10'h001;
    end
  end
  a_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data not zero outside read");
  a_misc_readback: assert property (wr_stb && addr == 16'hFFF1 ##2 rd_stb &&
    addr == 16'hFFF1 |=> rdata == {misc_s[7], 5'h00, misc_s[1:0]})
    else $error("misc readback wrong");
  a_mode_readback: assert property (wr_stb && addr == 16'h009B ##2 rd_stb &&
    addr == 16'h009B |=> rdata[7:6] == mode_s)
    else $error("mode bits readback wrong");
  a_pdn_follows: assert property (wr_stb && addr == 16'hFFF1 |=> ##1
    power_down == misc_s[7])
    else $error("power down output wrong");
  a_pdn_idle: assert property (power_down [*3] |-> tx_pin && rx_line_oe_b)
    else $error("pins active in power down");
  a_oe_mode0: assert property (!rx_line_oe_b |-> mode_s == 2'b00)
    else $error("rx pin driven outside shift mode");
  // Fixed rate runs are 64 or 32 clocks a bit, so every low run is a multiple of 32
  a_bit_grid: assert property ($rose(tx_pin) && mode_s == 2'b10 &&
    misc_s == 8'h00 |-> low_n[4:0] == 5'h00)
    else $error("fixed rate bit length wrong");
  a_low_bounded: assert property (low_n <= 10'h2BC)
    else $error("tx pin low too long");
  // Shift clock is low for half of a twelve-clock bit
  a_sclk_low: assert property ($rose(tx_pin) && mode_s == 2'b00 &&
    misc_s == 8'h00 |-> low_n == 10'h006)
    else $error("shift clock low phase wrong");
endmodule : dupsl_uart_checker
bind dupsl_uart dupsl_uart_checker chk_i (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .rx_line_oe_b(rx_line_oe_b), .tx_pin(tx_pin), .power_down(power_down));

// ### verification/dupsl_uart_tb.sv
`timescale 1ns/10ps
module dupsl_uart_tb;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        timer1_tick = 1'b0;
  logic [7:0]  rdata;
  logic        rx_line_drv, rx_line_oe_b, tx_pin, power_down, host_line;
  logic [9:0]  rx_word;
  logic [15:0] per = 16'h0040;
  logic [15:0] nb = 16'h0009;
  logic [15:0] rx_cnt;
  logic [7:0]  m0 = 8'h5A;
  int          fail_count = 0;
  int          n_tests = 0;
  wire         rx_wire = rx_line_oe_b ? host_line : rx_line_drv;
  always #20 sys_clk = ~sys_clk;
  // Timer ticks every other clock, the generator every clock
  always @(posedge sys_clk) timer1_tick <= ~timer1_tick;
  dupsl_uart dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .timer1_tick(timer1_tick), .brg_tick(1'b1), .rx_line(rx_wire),
    .rx_line_drv(rx_line_drv), .rx_line_oe_b(rx_line_oe_b), .tx_pin(tx_pin),
    .power_down(power_down));
  dupsl_host host (.sys_clk(sys_clk), .tx_pin(tx_pin), .rx_line(host_line), .per(per),
    .nb(nb), .rx_word(rx_word), .rx_cnt(rx_cnt));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    chk({2'b00, rdata}, {2'b00, exp});
  endtask : rd
  task automatic wf(input logic [9:0] exp);
    logic [15:0] c;
    c = rx_cnt;
    repeat (3000) if (rx_cnt == c) @(posedge sys_clk);
    // A frame that never arrives is a failure, not a stale compare
    if (rx_cnt == c) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, rx_cnt, c + 16'h0001);
      fail_count++;
    end
    chk(rx_word, exp);
  endtask : wf
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(16'hFFF1, 8'h00);
    rd(16'h009B, 8'h00);
    rd(16'h1234, 8'h00);
    $display("end reset");
    wr(16'h009B, 8'h88);
    wr(16'h0099, 8'hA5);
    wf(10'h3A5);
    rd(16'h009B, 8'h8A);
    wr(16'h009B, 8'h88);
    rd(16'h009B, 8'h88);
    $display("end mode 2 send");
    wr(16'h009B, 8'h50);
    nb = 16'h0008;
    host.send(10'h13C, 9);
    rd(16'h0099, 8'h3C);
    rd(16'h009B, 8'h55);
    $display("end mode 1 receive");
    wr(16'h00D8, 8'h80);
    wr(16'h0087, 8'h80);
    wr(16'h009B, 8'hC0);
    per = 16'h0010;
    nb = 16'h0009;
    wr(16'h0099, 8'h81);
    wf(10'h281);
    wr(16'h0087, 8'h00);
    wr(16'h00D8, 8'h00);
    $display("end mode 3 send");
    wr(16'h009B, 8'hB0);
    per = 16'h0040;
    host.send(10'h211, 10);
    rd(16'h009B, 8'hB0);
    rd(16'h0099, 8'h3C);
    host.send(10'h322, 10);
    rd(16'h0099, 8'h22);
    rd(16'h009B, 8'hB5);
    $display("end multiprocessor");
    wr(16'hFFF1, 8'h01);
    wr(16'h009E, 8'h18);
    per = 16'h0020;
    wr(16'h009F, 8'h42);
    wf(10'h342);
    wr(16'h009E, 8'h90);
    nb = 16'h0008;
    host.send(10'h17E, 9);
    rd(16'h009F, 8'h7E);
    rd(16'h009E, 8'h95);
    $display("end channel 1");
    wr(16'hFFF1, 8'h02);
    // Channel 1 only runs from the generator, so channel 0 must use it too
    wr(16'h00D8, 8'h80);
    wr(16'h009B, 8'h40);
    wr(16'h009E, 8'h90);
    per = 16'h0020;
    wr(16'h0099, 8'h96);
    wf(10'h196);
    rd(16'h009F, 8'h96);
    rd(16'h009E, 8'h95);
    $display("end loopback");
    wr(16'hFFF1, 8'h80);
    rd(16'hFFF1, 8'h80);
    chk({9'h000, power_down}, 10'h001);
    // Clear the done flag left by loopback so a refused send shows
    wr(16'h009B, 8'h40);
    wr(16'h0099, 8'h11);
    repeat (800) @(posedge sys_clk);
    rd(16'h009B, 8'h40);
    $display("end power down");
    wr(16'hFFF1, 8'h00);
    wr(16'h009B, 8'h00);
    wr(16'h0099, m0);
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_pin);
      chk({8'h00, rx_line_oe_b, rx_line_drv}, {9'h000, m0[i]});
    end
    repeat (10) @(posedge sys_clk);
    // Idle line reads as all ones in a shift mode receive
    wr(16'h009B, 8'h10);
    repeat (120) @(posedge sys_clk);
    rd(16'h0099, 8'hFF);
    rd(16'h009B, 8'h11);
    $display("end shift mode");
    complete_run();
  end
endmodule : dupsl_uart_tb
